// *** pkg/fbpl_defs.svh ***
// Constants for the fieldbus parameter set and the link-loss reaction.
// Assumes a 250 MHz clock; long tick counts are overridable module parameters.
`ifndef FBPL_DEFS_SVH
`define FBPL_DEFS_SVH

// Parameter numbers on the parameter channel
`define FBPL_PNU_REQ_MAP 16'h0393
`define FBPL_PNU_RSP_MAP 16'h0394
`define FBPL_PNU_NODE_ADDR 16'h0396
`define FBPL_PNU_WR_PERMIT 16'h039f
`define FBPL_PNU_FAULT_HIST 16'h03b3
`define FBPL_PNU_BAUD 16'h03c3
`define FBPL_PNU_PROFILE_VER 16'h03c5
`define FBPL_PNU_LAST_CTRL 16'h03c7
`define FBPL_PNU_LAST_STAT 16'h03c8
`define FBPL_PNU_INIT 16'h03ca

// History indices
`define FBPL_HIST_IDX0 8'h01
`define FBPL_HIST_IDX1 8'h09
`define FBPL_HIST_IDX2 8'h11
`define FBPL_HIST_IDX3 8'h19

// Reset and fixed values
`define FBPL_PROFILE_VER 16'h0002
`define FBPL_PERMIT_RST 16'h0001
`define FBPL_BAUD_MAX 4'ha
`define FBPL_LINK_FAULT_CODE 16'h7511
`define FBPL_LINK_ALARM_NUM 8'h23

// Access error codes returned in the answer
`define FBPL_ERR_NO_PARAM 8'h00
`define FBPL_ERR_WR_INHIBIT 8'h01
`define FBPL_ERR_RANGE 8'h02
`define FBPL_ERR_SUBINDEX 8'h03

// Timing: clock rate, millisecond and tenth-second ticks
`define FBPL_CLK_HZ 250000000
`define FBPL_MS_PER_S 1000
`define FBPL_CYC_PER_MS (`FBPL_CLK_HZ / `FBPL_MS_PER_S)
`define FBPL_MS_PER_TENTH 100
`define FBPL_DELAY_MAX 600

`endif

// *** pkg/fbpl_pkg.sv ***
// Types for the fieldbus parameter set and the link-loss reaction.
// Assumes fbpl_defs.svh supplies the numbers.
package fbpl_pkg;

  // Reaction controller states
  typedef enum logic [2:0] {
    FBPL_IDLE,
    FBPL_WAIT,
    FBPL_DECEL,
    FBPL_RUNON,
    FBPL_TRIPPED
  } fbpl_state_e;

  // What a reaction code asks for
  typedef enum logic [2:0] {
    FBPL_ACT_COAST_NOW,
    FBPL_ACT_DELAY_COAST,
    FBPL_ACT_CANCEL_COAST,
    FBPL_ACT_RUN_ON,
    FBPL_ACT_DECEL_NOW,
    FBPL_ACT_DELAY_DECEL,
    FBPL_ACT_CANCEL_DECEL
  } fbpl_action_e;

  // Reaction code to action
  function automatic fbpl_action_e fbplDecode(input logic [3:0] sel);
    fbpl_action_e a;
    a = FBPL_ACT_COAST_NOW;
    case (sel)
      4'h1: a = FBPL_ACT_DELAY_COAST;
      4'h2: a = FBPL_ACT_CANCEL_COAST;
      4'h3, 4'hd, 4'he, 4'hf: a = FBPL_ACT_RUN_ON;
      4'ha: a = FBPL_ACT_DECEL_NOW;
      4'hb: a = FBPL_ACT_DELAY_DECEL;
      4'hc: a = FBPL_ACT_CANCEL_DECEL;
      default: a = FBPL_ACT_COAST_NOW;
    endcase
    return a;
  endfunction

endpackage

// *** core/fbpl_core.sv ***
// Fieldbus slave parameter set and link-loss reaction controller.
// Assumes link framing logic on the same clock delivers decoded
// parameter requests and frame strobes; inverter logic consumes the
// stop, trip and init outputs and reports motor standstill.
`timescale 1ns/1ns
`include "fbpl_defs.svh"

module fbpl_core
  import fbpl_pkg::*;
#(
  parameter int CYC_PER_MS = `FBPL_CYC_PER_MS,
  parameter int MS_PER_TENTH = `FBPL_MS_PER_TENTH,
  parameter int WDT_W = 16,
  parameter int DELAY_W = 10
) (
  input wire logic clock,
  input wire logic sys_rst,
  // Parameter channel request
  input wire logic paramReq,
  input wire logic paramWrite,
  input wire logic [15:0] paramNum,
  input wire logic [7:0] paramIndex,
  input wire logic [15:0] paramWdata,
  // Parameter channel answer
  output logic paramAck,
  output logic paramErr,
  output logic [7:0] paramErrCode,
  output logic [15:0] paramRdata,
  // Link traffic
  input wire logic frameOk,
  input wire logic [WDT_W-1:0] masterWatchdog,
  input wire logic [15:0] ctrlWordIn,
  input wire logic [15:0] statusWordIn,
  input wire logic [6:0] nodeAddrIn,
  input wire logic [3:0] baudCodeIn,
  // Reaction settings
  input wire logic [3:0] lossReactionSelect,
  input wire logic [DELAY_W-1:0] lossReactionDelay,
  // Inverter side
  input wire logic motorStopped,
  input wire logic tripReset,
  input wire logic faultEvent,
  input wire logic [15:0] faultCodeIn,
  input wire logic [7:0] faultAlarmIn,
  output logic coastStop,
  output logic decelStop,
  output logic fieldbusErrorTrip,
  output logic commError,
  output logic powerIndicatorFlash,
  output logic offlineIndicatorRed,
  output logic dataInitStart,
  output logic [63:0] requestSlotMap,
  output logic [63:0] responseSlotMap,
  output logic [7:0] latestAlarmCode,
  output logic [7:0] previousAlarmCode,
  output logic [7:0] secondLastAlarmCode,
  output logic [7:0] thirdLastAlarmCode
);

  // Elaboration checks; the tenth counter is only eight bits wide
  if (CYC_PER_MS < 2 || MS_PER_TENTH < 1 || MS_PER_TENTH > 256 || WDT_W < 1) begin : gBadTick
    $error("fbpl_core: tick parameters out of range");
  end
  if (DELAY_W < 10 || DELAY_W > 16) begin : gBadDelay
    $error("fbpl_core: delay width cannot hold 60.0 s");
  end

  // Stored parameters
  logic [15:0] reqMap_q [4]; // Request slot entries
  logic [15:0] rspMap_q [4]; // Response slot entries
  logic permit_q; // Write permission
  logic init_q; // Initialize trigger value
  logic [15:0] lastCtrl_q; // Mirror of last control word
  logic [15:0] lastStat_q; // Mirror of last status word
  logic [15:0] histCode_q [4]; // Malfunction codes, newest first
  logic [7:0] histAlarm_q [4]; // Alarm numbers, newest first

  // Ticks and watchdog
  logic [31:0] msCnt_q; // Cycle count within one millisecond
  logic msTick; // One-cycle pulse each millisecond
  logic [7:0] tenthCnt_q; // Milliseconds within one tenth
  logic tenthTick; // One-cycle pulse each 0.1 s
  logic [WDT_W-1:0] wdtCnt_q; // Milliseconds without traffic
  logic wdtFired_q; // Timeout already reported
  logic errEvent; // Error detected this cycle
  logic armed_q; // A good frame has been seen

  // Reaction controller
  fbpl_state_e state_q;
  fbpl_action_e act_q; // Action latched at detection
  logic [DELAY_W-1:0] delayCnt_q; // Elapsed tenths
  logic tripNow; // Trip issued this cycle

  // Parameter channel decode
  logic hit;
  logic [15:0] rd;
  logic [7:0] ecode;
  logic err;
  logic idxOk; // Index 1..4 for slot arrays
  logic [1:0] slot;

  // Millisecond divider
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      msCnt_q <= 32'h0;
    end else if (msTick || errEvent) begin
      msCnt_q <= 32'h0; // Restart at detection so the delay counts whole tenths
    end else begin
      msCnt_q <= msCnt_q + 32'h1;
    end
  end
  assign msTick = (msCnt_q == 32'(CYC_PER_MS - 1));

  // Tenth-second divider on the millisecond tick
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tenthCnt_q <= 8'h0;
    end else if (tenthTick || errEvent) begin
      tenthCnt_q <= 8'h0;
    end else if (msTick) begin
      tenthCnt_q <= tenthCnt_q + 8'h1;
    end
  end
  assign tenthTick = msTick && (tenthCnt_q == 8'(MS_PER_TENTH - 1));

  // Watchdog: silence longer than the master's timeout is an error
  // A zero timeout means the master left its watchdog off
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wdtCnt_q <= '0;
      wdtFired_q <= 1'b0;
    end else if (frameOk) begin
      wdtCnt_q <= '0;
      wdtFired_q <= 1'b0;
    end else if (errEvent) begin
      wdtFired_q <= 1'b1;
    end else if (msTick && !wdtFired_q && wdtCnt_q != '1) begin
      wdtCnt_q <= wdtCnt_q + 1'b1;
    end
  end
  assign errEvent = !frameOk && !wdtFired_q && (masterWatchdog != '0) && (wdtCnt_q >= masterWatchdog);

  // Trip only after the first good frame since reset
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      armed_q <= 1'b0;
    end else if (frameOk) begin
      armed_q <= 1'b1;
    end
  end

  // Reaction state machine
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q <= FBPL_IDLE;
      act_q <= FBPL_ACT_COAST_NOW;
      delayCnt_q <= '0;
    end else begin
      unique case (state_q)
        FBPL_IDLE: begin
          // Errors before the link is armed are ignored
          if (errEvent && armed_q) begin
            act_q <= fbplDecode(lossReactionSelect);
            delayCnt_q <= '0;
            unique case (fbplDecode(lossReactionSelect))
              FBPL_ACT_COAST_NOW: state_q <= FBPL_TRIPPED;
              FBPL_ACT_RUN_ON: state_q <= FBPL_RUNON;
              FBPL_ACT_DECEL_NOW: state_q <= FBPL_DECEL;
              default: state_q <= FBPL_WAIT;
            endcase
          end
        end
        FBPL_WAIT: begin
          // Cancelling modes drop the error on any traffic
          if (frameOk && (act_q == FBPL_ACT_CANCEL_COAST || act_q == FBPL_ACT_CANCEL_DECEL)) begin
            state_q <= FBPL_IDLE;
          end else if (delayCnt_q >= lossReactionDelay) begin
            // Expiry ignores any resumed traffic in the other modes
            if (act_q == FBPL_ACT_DELAY_COAST || act_q == FBPL_ACT_CANCEL_COAST) begin
              state_q <= FBPL_TRIPPED;
            end else begin
              state_q <= FBPL_DECEL;
            end
          end else if (errEvent) begin
            delayCnt_q <= '0;
          end else if (tenthTick) begin
            delayCnt_q <= delayCnt_q + 1'b1;
          end
        end
        FBPL_DECEL: begin
          // Trip waits for standstill
          if (motorStopped) begin
            state_q <= FBPL_TRIPPED;
          end
        end
        FBPL_RUNON: begin
          // Never trips; clears when traffic returns
          if (frameOk) begin
            state_q <= FBPL_IDLE;
          end
        end
        FBPL_TRIPPED: begin
          if (tripReset) begin
            state_q <= FBPL_IDLE;
          end
        end
      endcase
    end
  end

  // Trip pulses when the tripped state is entered
  assign tripNow = (state_q != FBPL_TRIPPED) && (
      (state_q == FBPL_IDLE && errEvent && armed_q && fbplDecode(lossReactionSelect) == FBPL_ACT_COAST_NOW) ||
      (state_q == FBPL_WAIT && !(frameOk && (act_q == FBPL_ACT_CANCEL_COAST || act_q == FBPL_ACT_CANCEL_DECEL))
        && delayCnt_q >= lossReactionDelay
        && (act_q == FBPL_ACT_DELAY_COAST || act_q == FBPL_ACT_CANCEL_COAST)) ||
      (state_q == FBPL_DECEL && motorStopped));

  // Stop, trip and indicator outputs, registered
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fieldbusErrorTrip <= 1'b0;
      coastStop <= 1'b0;
      decelStop <= 1'b0;
      commError <= 1'b0;
      powerIndicatorFlash <= 1'b0;
      offlineIndicatorRed <= 1'b0;
    end else begin
      fieldbusErrorTrip <= tripNow;
      // Coast holds while tripped unless the stop came by ramp
      coastStop <= (state_q == FBPL_TRIPPED) && !(act_q == FBPL_ACT_DECEL_NOW || act_q == FBPL_ACT_DELAY_DECEL
        || act_q == FBPL_ACT_CANCEL_DECEL);
      decelStop <= (state_q == FBPL_DECEL);
      commError <= (state_q != FBPL_IDLE);
      powerIndicatorFlash <= (state_q == FBPL_RUNON);
      offlineIndicatorRed <= (state_q == FBPL_RUNON);
    end
  end

  // Mirrors of process words
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lastCtrl_q <= 16'h0;
      lastStat_q <= 16'h0;
    end else if (frameOk) begin
      lastCtrl_q <= ctrlWordIn;
      lastStat_q <= statusWordIn;
    end
  end

  // Fault history in both encodings; own trip wins a same-cycle clash
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) begin
        histCode_q[i] <= 16'h0;
        histAlarm_q[i] <= 8'h0;
      end
    end else if (tripNow || faultEvent) begin
      for (int i = 1; i < 4; i++) begin
        histCode_q[i] <= histCode_q[i-1];
        histAlarm_q[i] <= histAlarm_q[i-1];
      end
      histCode_q[0] <= tripNow ? `FBPL_LINK_FAULT_CODE : faultCodeIn;
      histAlarm_q[0] <= tripNow ? `FBPL_LINK_ALARM_NUM : faultAlarmIn;
    end
  end
  assign latestAlarmCode = histAlarm_q[0];
  assign previousAlarmCode = histAlarm_q[1];
  assign secondLastAlarmCode = histAlarm_q[2];
  assign thirdLastAlarmCode = histAlarm_q[3];

  // Slot decode shared by both mapping arrays
  assign idxOk = (paramIndex >= 8'h01) && (paramIndex <= 8'h04);
  assign slot = 2'(paramIndex - 8'h01);

  // Read data and error decode
  always_comb begin
    hit = 1'b1;
    rd = 16'h0;
    ecode = `FBPL_ERR_NO_PARAM;
    err = 1'b0;
    unique case (paramNum)
      `FBPL_PNU_REQ_MAP: rd = idxOk ? reqMap_q[slot] : 16'h0;
      `FBPL_PNU_RSP_MAP: rd = idxOk ? rspMap_q[slot] : 16'h0;
      `FBPL_PNU_NODE_ADDR: rd = {9'h0, nodeAddrIn};
      `FBPL_PNU_WR_PERMIT: rd = {15'h0, permit_q};
      `FBPL_PNU_FAULT_HIST: begin
        unique case (paramIndex)
          `FBPL_HIST_IDX0: rd = histCode_q[0];
          `FBPL_HIST_IDX1: rd = histCode_q[1];
          `FBPL_HIST_IDX2: rd = histCode_q[2];
          `FBPL_HIST_IDX3: rd = histCode_q[3];
          default: rd = 16'h0;
        endcase
      end
      `FBPL_PNU_BAUD: rd = (baudCodeIn > `FBPL_BAUD_MAX) ? 16'h0 : {12'h0, baudCodeIn};
      `FBPL_PNU_PROFILE_VER: rd = `FBPL_PROFILE_VER;
      `FBPL_PNU_LAST_CTRL: rd = lastCtrl_q;
      `FBPL_PNU_LAST_STAT: rd = lastStat_q;
      `FBPL_PNU_INIT: rd = {15'h0, init_q};
      default: hit = 1'b0;
    endcase
    if (!hit) begin
      err = 1'b1;
    end else if ((paramNum == `FBPL_PNU_REQ_MAP || paramNum == `FBPL_PNU_RSP_MAP) && !idxOk) begin
      err = 1'b1;
      ecode = `FBPL_ERR_SUBINDEX;
    end else if (paramWrite && !permit_q && paramNum != `FBPL_PNU_WR_PERMIT) begin
      err = 1'b1;
      ecode = `FBPL_ERR_WR_INHIBIT;
    end else if (paramWrite && !(paramNum == `FBPL_PNU_REQ_MAP || paramNum == `FBPL_PNU_RSP_MAP
        || paramNum == `FBPL_PNU_WR_PERMIT || paramNum == `FBPL_PNU_INIT)) begin
      err = 1'b1;
      ecode = `FBPL_ERR_WR_INHIBIT; // Read-only parameter
    end else if (paramWrite && (paramNum == `FBPL_PNU_WR_PERMIT || paramNum == `FBPL_PNU_INIT)
        && paramWdata > 16'h0001) begin
      err = 1'b1;
      ecode = `FBPL_ERR_RANGE;
    end
  end

  // Writable parameters
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) begin
        reqMap_q[i] <= 16'h0;
        rspMap_q[i] <= 16'h0;
      end
      permit_q <= 1'(`FBPL_PERMIT_RST);
      init_q <= 1'b0;
      dataInitStart <= 1'b0;
    end else begin
      dataInitStart <= 1'b0;
      if (paramReq && paramWrite && !err) begin
        unique case (paramNum)
          `FBPL_PNU_REQ_MAP: reqMap_q[slot] <= paramWdata;
          `FBPL_PNU_RSP_MAP: rspMap_q[slot] <= paramWdata;
          `FBPL_PNU_WR_PERMIT: permit_q <= paramWdata[0];
          `FBPL_PNU_INIT: begin
            init_q <= paramWdata[0];
            dataInitStart <= init_q && !paramWdata[0];
          end
          default: ;
        endcase
      end
    end
  end

  // Answer registered one cycle after the request
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      paramAck <= 1'b0;
      paramErr <= 1'b0;
      paramErrCode <= 8'h0;
      paramRdata <= 16'h0;
    end else begin
      paramAck <= paramReq;
      if (paramReq) begin
        paramErr <= err;
        paramErrCode <= err ? ecode : 8'h0;
        paramRdata <= err ? 16'h0 : (paramWrite ? paramWdata : rd);
      end
    end
  end

  // Flattened slot maps for the inverter
  for (genvar g = 0; g < 4; g++) begin : gSlot
    assign requestSlotMap[16*g +: 16] = reqMap_q[g];
    assign responseSlotMap[16*g +: 16] = rspMap_q[g];
  end

endmodule

// *** tb/fbpl_core_props.sv ***
// Checker for parameter answers and link-loss reactions.
// Assumes it is bound to fbpl_core and sees only its ports.
`timescale 1ns/1ns
`include "fbpl_defs.svh"
module fbpl_core_props (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic paramReq,
  input wire logic paramWrite,
  input wire logic [15:0] paramNum,
  input wire logic [7:0] paramIndex,
  input wire logic [15:0] paramWdata,
  input wire logic paramAck,
  input wire logic paramErr,
  input wire logic [7:0] paramErrCode,
  input wire logic [15:0] paramRdata,
  input wire logic frameOk,
  input wire logic [3:0] baudCodeIn,
  input wire logic [3:0] lossReactionSelect,
  input wire logic motorStopped,
  input wire logic coastStop,
  input wire logic decelStop,
  input wire logic fieldbusErrorTrip,
  input wire logic commError,
  input wire logic powerIndicatorFlash,
  input wire logic offlineIndicatorRed,
  input wire logic dataInitStart
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic armed_q; // Good frame seen since reset
  logic runOn; // Run-on reaction class
  logic coastNow; // Immediate coast class
  logic rd; // Read request this cycle
  assign runOn = lossReactionSelect == 4'h3 || lossReactionSelect >= 4'hd;
  assign coastNow = lossReactionSelect == 4'h0 || (lossReactionSelect >= 4'h4 && lossReactionSelect <= 4'h9);
  assign rd = paramReq && !paramWrite;
  // Arming tracker; errors before the first frame must stay silent
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      armed_q <= 1'b0;
    end else if (frameOk) begin
      armed_q <= 1'b1;
    end
  end
  AST_ACK_NEXT: assert property (paramReq |=> paramAck)
    else $error("no answer one cycle after request");
  AST_RO_REFUSE: assert property (paramReq && paramWrite && (paramNum == `FBPL_PNU_BAUD ||
    paramNum == `FBPL_PNU_FAULT_HIST) |=> paramErr && paramErrCode == 8'h01)
    else $error("read-only write not refused");
  AST_SLOT_INDEX: assert property (paramReq && (paramNum == `FBPL_PNU_REQ_MAP || paramNum == `FBPL_PNU_RSP_MAP) &&
    (paramIndex == 8'h00 || paramIndex > 8'h04) |=> paramErr && paramErrCode == 8'h03)
    else $error("bad slot index accepted");
  AST_BAUD_VALUE: assert property (rd && paramNum == `FBPL_PNU_BAUD |=> !paramErr &&
    paramRdata == (($past(baudCodeIn) > 4'ha) ? 16'h0000 : {12'h000, $past(baudCodeIn)}))
    else $error("baud report wrong");
  AST_HIST_ZERO: assert property (rd && paramNum == `FBPL_PNU_FAULT_HIST && paramIndex != 8'h01 &&
    paramIndex != 8'h09 && paramIndex != 8'h11 && paramIndex != 8'h19 |=> !paramErr && paramRdata == 16'h0000)
    else $error("unused history index not zero");
  AST_PERMIT_RANGE: assert property (paramReq && paramWrite && paramNum == `FBPL_PNU_WR_PERMIT &&
    paramWdata > 16'h0001 |=> paramErr && paramErrCode == 8'h02)
    else $error("permit value above one accepted");
  AST_UNARMED: assert property (!armed_q |-> !commError && !fieldbusErrorTrip)
    else $error("error raised before first frame");
  AST_COAST_NOW: assert property ($rose(commError) && coastNow |-> $past(fieldbusErrorTrip) && coastStop)
    else $error("immediate coast trip missing");
  AST_DECEL_NOW: assert property ($rose(commError) && lossReactionSelect == 4'ha |-> decelStop &&
    !fieldbusErrorTrip)
    else $error("immediate deceleration missing");
  AST_DECEL_TRIP: assert property (decelStop && $rose(motorStopped) |=> fieldbusErrorTrip)
    else $error("no trip after standstill");
  AST_RUNON_QUIET: assert property (runOn && $stable(lossReactionSelect) |-> !fieldbusErrorTrip)
    else $error("trip in run-on mode");
  AST_LEDS: assert property (powerIndicatorFlash |-> commError && offlineIndicatorRed)
    else $error("indicators out of step");
  AST_TRIP_PULSE: assert property (fieldbusErrorTrip |=> !fieldbusErrorTrip[*2])
    else $error("trip pulse too long");
  cover property (fieldbusErrorTrip && coastStop);
  cover property (decelStop && motorStopped);
  cover property (powerIndicatorFlash);
  cover property (dataInitStart);
endmodule
bind fbpl_core fbpl_core_props fbpl_core_props_i (.clock(clock), .sys_rst(sys_rst), .paramReq(paramReq),
  .paramWrite(paramWrite), .paramNum(paramNum), .paramIndex(paramIndex), .paramWdata(paramWdata),
  .paramAck(paramAck), .paramErr(paramErr), .paramErrCode(paramErrCode), .paramRdata(paramRdata),
  .frameOk(frameOk), .baudCodeIn(baudCodeIn), .lossReactionSelect(lossReactionSelect),
  .motorStopped(motorStopped), .coastStop(coastStop), .decelStop(decelStop),
  .fieldbusErrorTrip(fieldbusErrorTrip), .commError(commError), .powerIndicatorFlash(powerIndicatorFlash),
  .offlineIndicatorRed(offlineIndicatorRed), .dataInitStart(dataInitStart));

// *** tb/fbpl_master_model.sv ***
// Bus master stand-in: frame strobes with a control word.
// Assumes the bench clock; changes outputs on the falling edge.
`timescale 1ns/1ns
module fbpl_master_model #(
  parameter int GAP = 6
) (
  input wire logic clock,
  input wire logic run,
  output logic frameOk,
  output logic [15:0] ctrlWord
);
  int cnt = 0; // Cycles since last frame
  logic [15:0] word_q = 16'h0; // Last word sent
  // Word only valid with the strobe; inverted otherwise
  assign ctrlWord = frameOk ? word_q : ~word_q;
  // Frames spaced well inside the watchdog time
  always @(negedge clock) begin
    cnt <= (run && cnt < GAP - 1) ? cnt + 1 : 0;
    frameOk <= run && cnt == GAP - 1;
    if (run && cnt == GAP - 1) begin
      word_q <= word_q + 16'h1357;
    end
  end
  initial frameOk = 1'b0;
endmodule

// *** tb/fbpl_core_tb.sv ***
// Self-checking bench for the parameter set and loss reaction.
// Assumes fbpl_core, the master model and the checker are compiled.
`timescale 1ns/1ns
`include "fbpl_defs.svh"
module fbpl_core_tb;
  logic clock = 1'b0, sys_rst = 1'b1, paramReq = 1'b0, paramWrite = 1'b0;
  logic [15:0] paramNum = 16'h0, paramWdata = 16'h0, v, statusWordIn = 16'h0, faultCodeIn = 16'h0;
  logic [7:0] paramIndex = 8'h0, faultAlarmIn = 8'h0, paramErrCode;
  logic paramAck, paramErr, frameOk, mRun = 1'b0, motorStopped = 1'b0, faultEvent = 1'b0;
  logic [15:0] paramRdata, ctrlWord;
  logic [3:0] baudCodeIn = 4'h0, sel = 4'h0;
  logic coastStop, decelStop, trip, commError, pwrFlash, offRed, initStart;
  logic [63:0] reqMap, rspMap, reqExp = 64'h0, rspExp = 64'h0;
  logic [7:0] alarm [4]; // Newest first
  logic [15:0] hCode [4]; // Logged codes, oldest first
  logic [7:0] hAlarm [4];
  int err_count = 0, checked = 0, seed = 25, initPulses = 0, i, idx;
  // Small tick counts: tenth second is 8 cycles, watchdog 12
  fbpl_core #(.CYC_PER_MS(4), .MS_PER_TENTH(2)) fbpl_core_i (.clock(clock), .sys_rst(sys_rst),
    .paramReq(paramReq), .paramWrite(paramWrite), .paramNum(paramNum), .paramIndex(paramIndex),
    .paramWdata(paramWdata), .paramAck(paramAck), .paramErr(paramErr), .paramErrCode(paramErrCode),
    .paramRdata(paramRdata), .frameOk(frameOk), .masterWatchdog(16'h0003), .ctrlWordIn(ctrlWord),
    .statusWordIn(statusWordIn), .nodeAddrIn(statusWordIn[6:0]), .baudCodeIn(baudCodeIn), .lossReactionSelect(sel),
    .lossReactionDelay(10'h002), .motorStopped(motorStopped), .tripReset(1'b0), .faultEvent(faultEvent),
    .faultCodeIn(faultCodeIn), .faultAlarmIn(faultAlarmIn), .coastStop(coastStop), .decelStop(decelStop),
    .fieldbusErrorTrip(trip), .commError(commError), .powerIndicatorFlash(pwrFlash),
    .offlineIndicatorRed(offRed), .dataInitStart(initStart), .requestSlotMap(reqMap),
    .responseSlotMap(rspMap), .latestAlarmCode(alarm[0]), .previousAlarmCode(alarm[1]),
    .secondLastAlarmCode(alarm[2]), .thirdLastAlarmCode(alarm[3]));
  fbpl_master_model fbpl_master_model_i (.clock(clock), .run(mRun), .frameOk(frameOk), .ctrlWord(ctrlWord));
  always #2 clock = ~clock;
  // Count init pulses where outputs are settled
  always @(negedge clock) if (initStart === 1'b1) initPulses++;
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Reset with a new reaction code; code only moves under reset
  task automatic rst(input logic [3:0] c);
    @(negedge clock);
    sys_rst = 1'b1;
    mRun = 1'b0;
    motorStopped = 1'b0;
    sel = c;
    repeat (4) @(negedge clock);
    sys_rst = 1'b0;
  endtask
  // One parameter access; answer awaited under a bound
  task automatic acc(input logic wr, input logic [15:0] num, input logic [7:0] ix, input logic [15:0] wd);
    int n;
    @(negedge clock);
    {paramReq, paramWrite, paramNum, paramIndex, paramWdata} = {1'b1, wr, num, ix, wd};
    @(negedge clock);
    paramReq = 1'b0;
    for (n = 0; n < 4 && paramAck !== 1'b1; n++) @(negedge clock);
    if (n == 4) begin
      err_count++;
      close_out();
    end
  endtask
  task automatic rdx(input logic [15:0] num, input logic [7:0] ix, input logic [15:0] exp);
    acc(1'b0, num, ix, 16'h0);
    chk({paramErr, paramRdata}, {1'b0, exp});
  endtask
  task automatic erx(input logic [15:0] num, input logic [7:0] ix, input logic [15:0] wd, input logic [7:0] c);
    acc(1'b1, num, ix, wd);
    chk({paramErr, paramErrCode}, {1'b1, c});
  endtask
  function automatic logic [15:0] baudExp(input logic [3:0] c);
    return (c > 4'ha) ? 16'h0 : {12'h0, c};
  endfunction
  // Expected {trip, decel, late onset, coast at trip}
  function automatic logic [3:0] reactExp(input logic [3:0] c, input logic res);
    logic runOn, cancel, dec, dly;
    runOn = c == 4'h3 || c >= 4'hd;
    cancel = (c == 4'h2 || c == 4'hc) && res;
    dec = c >= 4'ha && c <= 4'hc;
    dly = c == 4'h1 || c == 4'h2 || c == 4'hb || c == 4'hc;
    return {!runOn && !cancel, dec && !cancel, dly && !cancel, !runOn && !cancel && !dec};
  endfunction
  // Traffic, then silence; optional resume just after the error
  task automatic react(input logic [3:0] c, input logic res);
    int t, rise, onset;
    logic sawTrip, sawDec, coastAt;
    rst(c);
    mRun = 1'b1;
    repeat (20) @(negedge clock);
    mRun = 1'b0;
    {rise, onset, sawTrip, sawDec, coastAt} = {-32'sd1, -32'sd1, 3'b000};
    for (t = 0; t < 150; t++) begin
      @(negedge clock);
      if (commError === 1'b1 && rise < 0) rise = t;
      if (res && rise >= 0 && t == rise + 4) mRun = 1'b1;
      if ((trip === 1'b1 || decelStop === 1'b1) && onset < 0) onset = t;
      if (sawTrip) coastAt = coastStop; // Coast is registered a cycle after the trip
      sawTrip |= trip === 1'b1;
      sawDec |= decelStop === 1'b1;
      motorStopped = decelStop === 1'b1 && t > onset + 5;
    end
    chk(rise >= 0, 1'b1);
    chk({sawTrip, sawDec, onset - rise >= 12, coastAt}, reactExp(c, res));
    if (c == 4'h0) begin
      rdx(`FBPL_PNU_FAULT_HIST, 8'h01, `FBPL_LINK_FAULT_CODE);
      chk(alarm[0], `FBPL_LINK_ALARM_NUM);
    end
  endtask
  initial begin
    #200000;
    err_count++;
    close_out();
  end
  initial begin
    rst(4'h3);
    statusWordIn = 16'($random(seed));
    rdx(`FBPL_PNU_WR_PERMIT, 8'h00, 16'h0001);
    // Random slot traffic, both maps
    for (i = 0; i < 8; i++) begin
      idx = ($unsigned($random(seed)) % 4) + 1;
      v = 16'($random(seed));
      reqExp[idx * 16 - 16 +: 16] = v;
      rspExp[idx * 16 - 16 +: 16] = ~v;
      acc(1'b1, `FBPL_PNU_REQ_MAP, 8'(idx), v);
      chk(reqMap, reqExp);
      acc(1'b1, `FBPL_PNU_RSP_MAP, 8'(idx), ~v);
      rdx(`FBPL_PNU_RSP_MAP, 8'(idx), ~v);
    end
    chk(rspMap, rspExp);
    erx(`FBPL_PNU_REQ_MAP, 8'h00, 16'h0, 8'h03);
    erx(`FBPL_PNU_RSP_MAP, 8'h05, 16'h0, 8'h03);
    // Write inhibit: only the permit itself stays writable
    erx(`FBPL_PNU_WR_PERMIT, 8'h00, 16'h0002, 8'h02);
    acc(1'b1, `FBPL_PNU_WR_PERMIT, 8'h00, 16'h0000);
    erx(`FBPL_PNU_REQ_MAP, 8'h01, 16'h1234, 8'h01);
    chk(reqMap, reqExp);
    acc(1'b1, `FBPL_PNU_WR_PERMIT, 8'h00, 16'h0001);
    chk(paramErr, 1'b0);
    for (i = 0; i < 12; i++) begin
      baudCodeIn = 4'(i);
      rdx(`FBPL_PNU_BAUD, 8'h00, baudExp(4'(i)));
    end
    erx(`FBPL_PNU_BAUD, 8'h00, 16'h0001, 8'h01);
    // Init fires on one-to-zero only
    acc(1'b1, `FBPL_PNU_INIT, 8'h00, 16'h0001);
    acc(1'b1, `FBPL_PNU_INIT, 8'h00, 16'h0000);
    acc(1'b1, `FBPL_PNU_INIT, 8'h00, 16'h0000);
    erx(`FBPL_PNU_INIT, 8'h00, 16'h0002, 8'h02);
    repeat (2) @(negedge clock);
    chk(initPulses, 1);
    // Four logged faults, newest read first
    for (i = 0; i < 4; i++) begin
      hCode[i] = 16'($random(seed));
      hAlarm[i] = 8'($random(seed));
      {faultCodeIn, faultAlarmIn, faultEvent} = {hCode[i], hAlarm[i], 1'b1};
      @(negedge clock);
      faultEvent = 1'b0;
    end
    for (i = 0; i < 4; i++) begin
      rdx(`FBPL_PNU_FAULT_HIST, 8'(8 * i + 1), hCode[3 - i]);
      chk(alarm[i], hAlarm[3 - i]);
    end
    rdx(`FBPL_PNU_FAULT_HIST, 8'h02, 16'h0000);
    // Silence from reset never trips
    rst(4'h0);
    v = 16'h0;
    repeat (60) begin
      @(negedge clock);
      v[0] = v[0] | commError | trip;
    end
    chk(v[0], 1'b0);
    for (i = 0; i < 16; i++) react(4'(i), 1'b1);
    react(4'h2, 1'b0);
    react(4'hc, 1'b0);
    close_out();
  end
endmodule
